// ---- verilog/perf_event_pkg.sv ----
// package of constants for the performance event selection block
// assumes a 32-bit register port with word-aligned byte addresses
package perf_event_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_SELECT0 = 4'h0;
  localparam logic [3:0] ADDR_SELECT1 = 4'h4;
  localparam logic [3:0] ADDR_COUNT0 = 4'h8;
  localparam logic [3:0] ADDR_COUNT1 = 4'hC;

  // ----------------------------------------------------------------
  // select register fields and reset values
  // ----------------------------------------------------------------
  localparam int SEL_CODE_LSB = 0;
  localparam int SEL_MASK_LSB = 8;
  localparam int SEL_ENABLE_BIT = 22;
  localparam int MASK_ANY_BIT = 5;
  localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam logic [3:0] MESI_NONE = 4'h0;

  // ----------------------------------------------------------------
  // event codes
  // ----------------------------------------------------------------
  localparam logic [7:0] EV_DATA_MEM_REFERENCES = 8'h43;
  localparam logic [7:0] EV_L1D_LINES_ALLOCATED = 8'h45;
  localparam logic [7:0] EV_L1D_MOD_LINES_ALLOCATED = 8'h46;
  localparam logic [7:0] EV_L1D_MOD_LINES_EVICTED = 8'h47;
  localparam logic [7:0] EV_L1D_MISS_PENDING_CYCLES = 8'h48;
  localparam logic [7:0] EV_FETCH_COUNT = 8'h80;
  localparam logic [7:0] EV_FETCH_MISS_COUNT = 8'h81;
  localparam logic [7:0] EV_CODE_TRANSLATION_MISS = 8'h85;
  localparam logic [7:0] EV_FETCH_STAGE_STALL = 8'h86;
  localparam logic [7:0] EV_LENGTH_DECODER_STALL = 8'h87;
  localparam logic [7:0] EV_L2_CODE_FETCHES = 8'h28;
  localparam logic [7:0] EV_L2_DATA_LOADS = 8'h29;
  localparam logic [7:0] EV_L2_DATA_STORES = 8'h2A;
  localparam logic [7:0] EV_L2_REQUEST_COUNT = 8'h2E;
  localparam logic [7:0] EV_L2_LINES_ALLOCATED = 8'h24;
  localparam logic [7:0] EV_L2_MOD_LINES_ALLOCATED = 8'h25;
  localparam logic [7:0] EV_L2_LINES_REMOVED = 8'h26;
  localparam logic [7:0] EV_L2_MOD_LINES_REMOVED = 8'h27;
  localparam logic [7:0] EV_L2_ADDRESS_STROBES = 8'h21;
  localparam logic [7:0] EV_L2_DATABUS_BUSY = 8'h22;
  localparam logic [7:0] EV_L2_DATABUS_BUSY_READ = 8'h23;
  localparam logic [7:0] EV_BUS_REQ_PENDING = 8'h60;
  localparam logic [7:0] EV_BUS_BLOCK_NEXT_DRIVEN = 8'h61;
  localparam logic [7:0] EV_DATA_READY_CLOCKS = 8'h62;
  localparam logic [7:0] EV_BUS_LOCK_CLOCKS = 8'h63;
  localparam logic [7:0] EV_BUS_DATA_RECEIVE = 8'h64;
  localparam logic [7:0] EV_BUS_TRAN_FIRST = 8'h65;
  localparam logic [7:0] EV_BUS_TRAN_MEMORY = 8'h6F;
  localparam logic [7:0] EV_BUS_TRAN_ALL = 8'h70;
  localparam logic [7:0] EV_BUS_HIT_DRIVEN = 8'h7A;
  localparam logic [7:0] EV_BUS_HIT_MOD_DRIVEN = 8'h7B;
  localparam logic [7:0] EV_BUS_SNOOP_STALL = 8'h7E;
  localparam logic [7:0] EV_RETIRED_FP_OPERATIONS = 8'hC1;

  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int BUS_TRAN_KINDS = 12;
  localparam int ALL_TRAN_INDEX = 11;
  localparam logic [1:0] L2_MISS_SHORTFALL = 2'h2;
  localparam logic [1:0] SHORTFALL_IDLE = 2'h0;

endpackage

// ---- verilog/perf_event_selection_logic.sv ----
// event selection and two performance counters behind a register port
// assumes event inputs synchronous to clk_sys, bus clock given as a tick
`timescale 1ns/1ps

module perf_event_selection_logic (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // first-level data cache events
  input wire logic data_memory_references,
  input wire logic l1d_lines_allocated,
  input wire logic l1d_modified_lines_allocated,
  input wire logic l1d_modified_lines_evicted,
  input wire logic [3:0] l1d_miss_pending_cycles,
  input wire logic l1d_miss_also_l2,
  // instruction fetch events
  input wire logic fetch_count,
  input wire logic fetch_miss_count,
  input wire logic code_translation_miss,
  input wire logic fetch_stage_stall_cycles,
  input wire logic length_decoder_stall_cycles,
  // second-level cache events, fetches, loads, stores and requests one bit per MESI state
  input wire logic [3:0] l2_code_fetches,
  input wire logic [3:0] l2_data_loads,
  input wire logic [3:0] l2_data_stores,
  input wire logic [3:0] l2_request_count,
  input wire logic l2_lines_allocated,
  input wire logic l2_modified_lines_allocated,
  input wire logic l2_lines_removed,
  input wire logic l2_modified_lines_removed,
  input wire logic l2_address_strobe_count,
  input wire logic l2_databus_busy_cycles,
  input wire logic l2_databus_busy_read_cycles,
  // external bus events
  input wire logic bus_clock_tick,
  input wire logic data_ready_clock_count,
  input wire logic data_ready_any_agent,
  input wire logic bus_lock_self,
  input wire logic bus_lock_any,
  input wire logic [3:0] bus_read_pending_count,
  input wire logic [11:0] bus_tran_self,
  input wire logic [11:0] bus_tran_any,
  input wire logic block_next_request_pin,
  input wire logic snoop_hit_pin,
  input wire logic snoop_hit_modified_pin,
  input wire logic bus_data_receive,
  input wire logic bus_snoop_stall,
  // floating-point events
  input wire logic retired_fp_operations,
  // counter values
  output logic [31:0] count0,
  output logic [31:0] count1
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] select0;
    logic [31:0] select1;
    logic [31:0] count0;
    logic [31:0] count1;
    logic [31:0] rdata;
    logic [1:0] shortfall;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // one-bit occurrence widened to an increment
  function automatic logic [3:0] one(input logic hit);
    one = {3'h0, hit};
  endfunction

  // counter advanced by one cycle's increment, wrapping at 32 bits
  function automatic logic [31:0] count_step(input logic [31:0] count, input logic [3:0] inc);
    count_step = count + {28'h0, inc};
  endfunction

  // any cache state of this access that the mask selects
  function automatic logic state_hit(input logic [3:0] states, input logic [3:0] mesi);
    state_hit = |(states & mesi);
  endfunction

  // level counted only in cycles that carry a bus clock tick
  function automatic logic bus_clocked(input logic level);
    bus_clocked = level & bus_clock_tick;
  endfunction

  // self or any-agent source, chosen by the scope bit of the mask
  function automatic logic agent_pick(input logic any, input logic self_src,
                                      input logic any_src);
    agent_pick = any ? any_src : self_src;
  endfunction

  // increment selected by code and mask for one counter
  function automatic logic [3:0] event_inc(input logic [31:0] sel, input logic is_ctr0,
                                           input logic [3:0] miss_weight);
    logic [7:0] code;
    logic [7:0] mask;
    logic any;
    logic [3:0] mesi;
    logic [3:0] tran_idx;
    code = sel[perf_event_pkg::SEL_CODE_LSB +: 8];
    mask = sel[perf_event_pkg::SEL_MASK_LSB +: 8];
    any = mask[perf_event_pkg::MASK_ANY_BIT];
    mesi = mask[3:0];
    tran_idx = 4'(code - perf_event_pkg::EV_BUS_TRAN_FIRST);
    event_inc = 4'h0;
    if (!sel[perf_event_pkg::SEL_ENABLE_BIT]) begin
      event_inc = 4'h0;
    end else begin
      case (code)
        perf_event_pkg::EV_DATA_MEM_REFERENCES: begin
          event_inc = one(data_memory_references);
        end
        perf_event_pkg::EV_L1D_LINES_ALLOCATED: begin
          event_inc = one(l1d_lines_allocated);
        end
        perf_event_pkg::EV_L1D_MOD_LINES_ALLOCATED: begin
          event_inc = one(l1d_modified_lines_allocated);
        end
        perf_event_pkg::EV_L1D_MOD_LINES_EVICTED: begin
          event_inc = one(l1d_modified_lines_evicted);
        end
        perf_event_pkg::EV_L1D_MISS_PENDING_CYCLES: begin
          event_inc = miss_weight;
        end
        perf_event_pkg::EV_FETCH_COUNT: begin
          event_inc = one(fetch_count);
        end
        perf_event_pkg::EV_FETCH_MISS_COUNT: begin
          event_inc = one(fetch_miss_count);
        end
        perf_event_pkg::EV_CODE_TRANSLATION_MISS: begin
          event_inc = one(code_translation_miss);
        end
        perf_event_pkg::EV_FETCH_STAGE_STALL: begin
          event_inc = one(fetch_stage_stall_cycles);
        end
        perf_event_pkg::EV_LENGTH_DECODER_STALL: begin
          event_inc = one(length_decoder_stall_cycles);
        end
        perf_event_pkg::EV_L2_CODE_FETCHES: begin
          event_inc = one(state_hit(l2_code_fetches, mesi));
        end
        perf_event_pkg::EV_L2_DATA_LOADS: begin
          event_inc = one(state_hit(l2_data_loads, mesi));
        end
        perf_event_pkg::EV_L2_DATA_STORES: begin
          event_inc = one(state_hit(l2_data_stores, mesi));
        end
        perf_event_pkg::EV_L2_REQUEST_COUNT: begin
          event_inc = one(state_hit(l2_request_count, mesi));
        end
        perf_event_pkg::EV_L2_LINES_ALLOCATED: begin
          event_inc = one(l2_lines_allocated);
        end
        perf_event_pkg::EV_L2_LINES_REMOVED: begin
          event_inc = one(l2_lines_removed);
        end
        perf_event_pkg::EV_L2_MOD_LINES_ALLOCATED: begin
          event_inc = one(l2_modified_lines_allocated);
        end
        perf_event_pkg::EV_L2_MOD_LINES_REMOVED: begin
          event_inc = one(l2_modified_lines_removed);
        end
        perf_event_pkg::EV_L2_ADDRESS_STROBES: begin
          event_inc = one(l2_address_strobe_count);
        end
        perf_event_pkg::EV_L2_DATABUS_BUSY: begin
          event_inc = one(l2_databus_busy_cycles);
        end
        perf_event_pkg::EV_L2_DATABUS_BUSY_READ: begin
          event_inc = one(l2_databus_busy_read_cycles);
        end
        perf_event_pkg::EV_DATA_READY_CLOCKS: begin
          // self counts bus clocks, any counts processor clocks
          event_inc = one(agent_pick(any, bus_clocked(data_ready_clock_count),
                                     data_ready_any_agent));
        end
        perf_event_pkg::EV_BUS_LOCK_CLOCKS: begin
          event_inc = one(agent_pick(any, bus_lock_self, bus_lock_any));
        end
        perf_event_pkg::EV_BUS_REQ_PENDING: begin
          event_inc = bus_read_pending_count;
        end
        perf_event_pkg::EV_BUS_BLOCK_NEXT_DRIVEN: begin
          event_inc = one(bus_clocked(block_next_request_pin));
        end
        perf_event_pkg::EV_BUS_HIT_DRIVEN: begin
          event_inc = one(bus_clocked(snoop_hit_pin));
        end
        perf_event_pkg::EV_BUS_HIT_MOD_DRIVEN: begin
          event_inc = one(bus_clocked(snoop_hit_modified_pin));
        end
        perf_event_pkg::EV_BUS_DATA_RECEIVE: begin
          event_inc = one(bus_clocked(bus_data_receive));
        end
        perf_event_pkg::EV_BUS_SNOOP_STALL: begin
          event_inc = one(bus_snoop_stall);
        end
        perf_event_pkg::EV_BUS_TRAN_ALL: begin
          event_inc = one(agent_pick(any, bus_tran_self[perf_event_pkg::ALL_TRAN_INDEX],
                                     bus_tran_any[perf_event_pkg::ALL_TRAN_INDEX]));
        end
        perf_event_pkg::EV_RETIRED_FP_OPERATIONS: begin
          event_inc = one(is_ctr0 & retired_fp_operations);
        end
        default: begin
          // transactions 65H through 6FH share one indexed decode
          if (code >= perf_event_pkg::EV_BUS_TRAN_FIRST &&
              code <= perf_event_pkg::EV_BUS_TRAN_MEMORY) begin
            event_inc = one(agent_pick(any, bus_tran_self[tran_idx],
                                       bus_tran_any[tran_idx]));
          end else begin
            event_inc = 4'h0;
          end
        end
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic [3:0] miss_weight;
  logic [3:0] inc0;
  logic [3:0] inc1;

  // miss weight loses one cycle for each of the two after an L2 miss
  always_comb begin
    if (st_reg.shortfall != perf_event_pkg::SHORTFALL_IDLE &&
        l1d_miss_pending_cycles != 4'h0) begin
      miss_weight = l1d_miss_pending_cycles - 4'h1;
    end else begin
      miss_weight = l1d_miss_pending_cycles;
    end
    inc0 = event_inc(st_reg.select0, 1'b1, miss_weight);
    inc1 = event_inc(st_reg.select1, 1'b0, miss_weight);
  end

  // register port, counters and shortfall window
  always_comb begin
    st_next = st_reg;
    // a new L2 miss restarts the shortfall window, winning over the countdown
    if (l1d_miss_also_l2) begin
      st_next.shortfall = perf_event_pkg::L2_MISS_SHORTFALL;
    end else if (st_reg.shortfall != perf_event_pkg::SHORTFALL_IDLE) begin
      st_next.shortfall = st_reg.shortfall - 2'h1;
    end
    // counters advance, a counter write below takes precedence
    st_next.count0 = count_step(st_reg.count0, inc0);
    st_next.count1 = count_step(st_reg.count1, inc1);
    // read data stand for one cycle only
    st_next.rdata = perf_event_pkg::READ_ZERO;
    // register writes, unmapped addresses ignored
    if (reg_write) begin
      case (reg_addr)
        perf_event_pkg::ADDR_SELECT0: begin
          st_next.select0 = reg_wdata;
        end
        perf_event_pkg::ADDR_SELECT1: begin
          st_next.select1 = reg_wdata;
        end
        perf_event_pkg::ADDR_COUNT0: begin
          st_next.count0 = reg_wdata;
        end
        perf_event_pkg::ADDR_COUNT1: begin
          st_next.count1 = reg_wdata;
        end
        default: begin
          st_next.select0 = st_reg.select0;
        end
      endcase
    end
    // register reads, unmapped addresses return zero
    if (reg_read) begin
      case (reg_addr)
        perf_event_pkg::ADDR_SELECT0: begin
          st_next.rdata = st_reg.select0;
        end
        perf_event_pkg::ADDR_SELECT1: begin
          st_next.rdata = st_reg.select1;
        end
        perf_event_pkg::ADDR_COUNT0: begin
          st_next.rdata = st_reg.count0;
        end
        perf_event_pkg::ADDR_COUNT1: begin
          st_next.rdata = st_reg.count1;
        end
        default: begin
          st_next.rdata = perf_event_pkg::READ_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg.select0 <= perf_event_pkg::SELECT_RESET;
      st_reg.select1 <= perf_event_pkg::SELECT_RESET;
      st_reg.count0 <= perf_event_pkg::COUNT_RESET;
      st_reg.count1 <= perf_event_pkg::COUNT_RESET;
      st_reg.rdata <= perf_event_pkg::READ_ZERO;
      st_reg.shortfall <= perf_event_pkg::SHORTFALL_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = st_reg.rdata;
  assign count0 = st_reg.count0;
  assign count1 = st_reg.count1;

endmodule

// ---- testbench/perf_event_checker.sv ----
// assertions on the register port and counters of the event selection block
// assumes it is bound to the block's top module and sees only its ports
`timescale 1ns/1ps

module perf_event_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  // counter values
  input wire logic [31:0] count0,
  input wire logic [31:0] count1
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  logic w0;
  logic w1;
  // counter writes, which win over any increment in the same cycle
  assign w0 = reg_write && reg_addr == perf_event_pkg::ADDR_COUNT0;
  assign w1 = reg_write && reg_addr == perf_event_pkg::ADDR_COUNT1;
  rdata_idle_zero_a: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property (reg_read && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  count0_write_a: assert property (w0 |=> count0 == $past(reg_wdata))
    else $error("counter 0 did not take written value");
  count1_write_a: assert property (w1 |=> count1 == $past(reg_wdata))
    else $error("counter 1 did not take written value");
  count0_read_a: assert property (reg_read && reg_addr == perf_event_pkg::ADDR_COUNT0
    |=> reg_rdata == $past(count0)) else $error("counter 0 read value wrong");
  count1_read_a: assert property (reg_read && reg_addr == perf_event_pkg::ADDR_COUNT1
    |=> reg_rdata == $past(count1)) else $error("counter 1 read value wrong");
  count0_step_a: assert property (!w0 |=> count0 - $past(count0) <= 32'hF)
    else $error("counter 0 jumped too far in one cycle");
  count1_step_a: assert property (!w1 |=> count1 - $past(count1) <= 32'hF)
    else $error("counter 1 jumped too far in one cycle");
  // main scenarios seen
  cover property (reg_read && reg_addr == perf_event_pkg::ADDR_COUNT0);
  cover property (!w0 ##1 count0 != $past(count0));
  cover property (reg_read && reg_addr[1:0] != 2'h0);
endmodule

bind perf_event_selection_logic perf_event_checker perf_event_checker_i (
  .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .count0(count0), .count1(count1)
);

// ---- testbench/tb_perf_event_selection_logic.sv ----
// self-checking bench for the performance event selection block
// assumes the package, the block and its checker are compiled first
`timescale 1ns/1ps

module tb_perf_event_selection_logic;
  // ----------------------------------------------------------------
  // stimulus and checking state
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] count0;
  logic [31:0] count1;
  logic [31:0] got;
  logic act = 1'b0;
  logic tick = 1'b0;
  logic sp = 1'b0;
  logic [25:0] p1 = 26'h0;
  logic [25:0] e;
  logic [15:0] pl2 = 16'h0;
  logic [3:0] pw = 4'h0;
  logic [3:0] pp = 4'h0;
  logic [11:0] pts = 12'h0;
  logic [11:0] pta = 12'h0;
  logic [7:0] ctab [26] = '{8'h43, 8'h45, 8'h46, 8'h47, 8'h80, 8'h81, 8'h85, 8'h86, 8'h87,
    8'h24, 8'h25, 8'h26, 8'h27, 8'h21, 8'h22, 8'h23, 8'h62, 8'h62, 8'h63, 8'h63,
    8'h61, 8'h7A, 8'h7B, 8'h64, 8'h7E, 8'hC1};
  logic [7:0] l2c [4] = '{8'h28, 8'h29, 8'h2A, 8'h2E};
  int failures = 0;
  int compares = 0;

  // event patterns reach the block only while act is high
  assign e = act ? p1 : 26'h0;
  // processor clock, and a bus clock tick in every second cycle
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) tick <= ~tick;

  perf_event_selection_logic perf_event_selection_logic_i (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .data_memory_references(e[0]), .l1d_lines_allocated(e[1]),
    .l1d_modified_lines_allocated(e[2]), .l1d_modified_lines_evicted(e[3]),
    .l1d_miss_pending_cycles(act ? pw : 4'h0), .l1d_miss_also_l2(sp),
    .fetch_count(e[4]), .fetch_miss_count(e[5]), .code_translation_miss(e[6]),
    .fetch_stage_stall_cycles(e[7]), .length_decoder_stall_cycles(e[8]),
    .l2_code_fetches(act ? pl2[3:0] : 4'h0), .l2_data_loads(act ? pl2[7:4] : 4'h0),
    .l2_data_stores(act ? pl2[11:8] : 4'h0), .l2_request_count(act ? pl2[15:12] : 4'h0),
    .l2_lines_allocated(e[9]), .l2_modified_lines_allocated(e[10]),
    .l2_lines_removed(e[11]), .l2_modified_lines_removed(e[12]),
    .l2_address_strobe_count(e[13]), .l2_databus_busy_cycles(e[14]),
    .l2_databus_busy_read_cycles(e[15]), .bus_clock_tick(tick),
    .data_ready_clock_count(e[16]), .data_ready_any_agent(e[17]), .bus_lock_self(e[18]),
    .bus_lock_any(e[19]), .bus_read_pending_count(act ? pp : 4'h0),
    .bus_tran_self(act ? pts : 12'h0), .bus_tran_any(act ? pta : 12'h0),
    .block_next_request_pin(e[20]), .snoop_hit_pin(e[21]), .snoop_hit_modified_pin(e[22]),
    .bus_data_receive(e[23]), .bus_snoop_stall(e[24]), .retired_fp_operations(e[25]),
    .count0(count0), .count1(count1)
  );

  // ----------------------------------------------------------------
  // bus cycles, comparison and one counting run
  // ----------------------------------------------------------------
  function automatic logic [31:0] sv(input logic [7:0] code, input logic [7:0] mask);
    return (32'h1 << perf_event_pkg::SEL_ENABLE_BIT) | {16'h0, mask, code};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      failures++;
      $display("BAD at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    got = reg_rdata;
  endtask
  // preset the counter near wrap, apply patterns for four cycles, read back
  task automatic run(input logic c, input logic [31:0] sel, input logic s, input int x);
    logic [3:0] ca;
    ca = c ? perf_event_pkg::ADDR_COUNT1 : perf_event_pkg::ADDR_COUNT0;
    wr(c ? perf_event_pkg::ADDR_SELECT1 : perf_event_pkg::ADDR_SELECT0, sel);
    wr(ca, 32'hFFFF_FFFE);
    @(posedge clk_sys);
    act <= 1'b1;
    sp <= s;
    @(posedge clk_sys);
    sp <= 1'b0;
    repeat (3) @(posedge clk_sys);
    act <= 1'b0;
    rd(ca);
    check(got, 32'hFFFF_FFFE + 32'(x));
    check(c ? count1 : count0, 32'hFFFF_FFFE + 32'(x));
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog, far beyond the fewer than two thousand cycles the tests need
  initial begin
    #200000;
    failures++;
    complete_run();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      rd(a < 4 ? 4'(4 * a) : 4'h6);
      check(got, 32'h0);
    end
    wr(perf_event_pkg::ADDR_SELECT1, 32'hA5BF_5A3C);
    rd(perf_event_pkg::ADDR_SELECT1);
    check(got, 32'hA5BF_5A3C);
    wr(4'h6, 32'hFFFF_FFFF);
    rd(perf_event_pkg::ADDR_SELECT0);
    check(got, 32'h0);
    wr(perf_event_pkg::ADDR_SELECT1, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 26; i++) begin
      p1 = 26'h1 << i;
      run(1'b0, sv(ctab[i], (i == 17 || i == 19) ? 8'h20 : 8'h00), 1'b0,
        (i == 16 || (i > 19 && i < 24)) ? 2 : 4);
      run(1'b0, sv(ctab[(i + 13) % 26], ((i + 13) % 26 == 17 || (i + 13) % 26 == 19)
        ? 8'h20 : 8'h00), 1'b0, 0);
    end
    run(1'b1, sv(8'hC1, 8'h00), 1'b0, 0);
    p1 = 26'h1;
    run(1'b1, sv(8'h43, 8'h00), 1'b0, 4);
    $display("test single events done");
    for (int k = 0; k < 16; k++) begin
      pl2 = 16'h1 << k;
      run(1'b0, sv(l2c[k / 4], 8'h1 << (k % 4)), 1'b0, 4);
      run(1'b0, sv(l2c[k / 4], 8'h0F & ~(8'h1 << (k % 4))), 1'b0, 0);
      run(1'b0, sv(l2c[k / 4], 8'h00), 1'b0, 0);
    end
    pl2 = 16'h0;
    $display("test cache state masks done");
    pw = 4'h3;
    run(1'b0, sv(8'h48, 8'h00), 1'b0, 12);
    run(1'b0, sv(8'h48, 8'h00), 1'b1, 10);
    pw = 4'h0;
    pp = 4'h5;
    run(1'b0, sv(8'h60, 8'h00), 1'b0, 20);
    pp = 4'h0;
    $display("test weighted counts done");
    for (int i = 0; i < 12; i++) begin
      pts = 12'h1 << i;
      pta = 12'h0;
      run(1'b0, sv(8'(8'h65 + i), 8'h00), 1'b0, 4);
      run(1'b0, sv(8'(8'h65 + i), 8'h20), 1'b0, 0);
      pts = 12'h0;
      pta = 12'h1 << i;
      run(1'b0, sv(8'(8'h65 + i), 8'h20), 1'b0, 4);
      run(1'b0, sv(8'(8'h65 + i), 8'h00), 1'b0, 0);
    end
    pta = 12'h0;
    $display("test bus transactions done");
    p1 = 26'h3FF_FFFF;
    run(1'b0, sv(8'h44, 8'h00), 1'b0, 0);
    run(1'b0, 32'h0000_0043, 1'b0, 0);
    p1 = 26'h0;
    $display("test reserved and disabled done");
    complete_run();
  end
endmodule
